/* pms_pkg.sv */
// Purpose: Shared constants and types for the power mode sequencer
// Assumes: Everything runs on the slow oscillator clock
// Notes:   Sequence figures are counts of slow oscillator cycles
//
// Functional notes
// - Mode timing runs from the slow oscillator, which never stops.
// - Processing enables every domain, runs the processor, keeps peripherals active.
// - Deep Sleep drops flash and analog supplies, keeps core supply on.
// - Deep Sleep halts processor, stops fast oscillator and watchdog, arms host pins.
// - Deep Sleep exits only on wake line, I2C start or a system reset.
// - Deep Sleep is entered only on a host command.
// - Self Wake-up alternates autonomously between sleep and scan phases.
// - Scans are timed by a programmable slow-clock wake-up timer.
// - Self Wake-up entered on host command or non-activity timeout.
// - Self Wake-up sleep phase exits on timer overflow, wake, I2C start, or resets.
// - Wake-up from the sleep phase completes quickly, well under 1 ms.
// - Scan phase activates only the receive channels set in the scan channel mask.
// - After reset: reference 0, fast osc 2, processor clock 30, done 36.
// - After Deep Sleep: reference 0, fast osc 2, processor clock 8, done 10.
// - Processing starts after the power-up timeout, or directly on a wake in the scan phase.
// - Deep Sleep entry passes through power-down with analog enables removed.
// - System start is held off until the 36-cycle timeout elapses.
// - Master clear, software reset and watchdog reset form one system reset.
`default_nettype none
package pms_pkg;
  localparam int          SLOW_CLK_HZ      = 32000;
  localparam int          WAKE_MAX_US      = 1000;
  localparam int          WAKE_MAX_CYCLES  = (WAKE_MAX_US * SLOW_CLK_HZ) / 1000000;
  localparam logic [5:0]  RST_FAST_OSC_AT  = 6'h02;
  localparam logic [5:0]  RST_PROC_CLK_AT  = 6'h1E;
  localparam logic [5:0]  RST_DONE_AT      = 6'h24;
  localparam logic [5:0]  DS_FAST_OSC_AT   = 6'h02;
  localparam logic [5:0]  DS_PROC_CLK_AT   = 6'h08;
  localparam logic [5:0]  DS_DONE_AT       = 6'h0A;
  localparam int          RX_CHANNELS      = 5;
  localparam logic [15:0] WAKE_PERIOD_RST  = 16'h0280;
  localparam logic [15:0] SCAN_LEN_RST     = 16'h0010;

  typedef enum logic [2:0] {
    PMS_POWER_UP   = 3'b000,
    PMS_PROCESSING = 3'b001,
    PMS_POWER_DOWN = 3'b010,
    PMS_DEEP_SLEEP = 3'b011,
    PMS_SW_SLEEP   = 3'b100,
    PMS_SW_SCAN    = 3'b101
  } pms_state_t;
endpackage
`default_nettype wire

/* pms_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Inputs come from pins outside the slow clock domain
// Notes:   First stage feeds only the second stage
`default_nettype none
module pms_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* pms_seq_timer.sv */
// Purpose: Power-up sequence counter driving the staged enables
// Assumes: start pulses for one cycle; profile chosen on that cycle
// Notes:   Reference enable rises with start, at cycle 0
`default_nettype none
module pms_seq_timer
  import pms_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic start,
  input  wire logic from_deep_sleep,
  input  wire logic abort,
  // Stage flags
  output logic      running,
  output logic      fast_osc_stage,
  output logic      proc_clk_stage,
  output logic      done
);
  logic [5:0] count_reg;
  logic       profile_ds_reg;
  logic [5:0] osc_at;
  logic [5:0] clk_at;
  logic [5:0] done_at;

  always_comb begin
    osc_at  = profile_ds_reg ? DS_FAST_OSC_AT : RST_FAST_OSC_AT;
    clk_at  = profile_ds_reg ? DS_PROC_CLK_AT : RST_PROC_CLK_AT;
    done_at = profile_ds_reg ? DS_DONE_AT : RST_DONE_AT;
  end

  always_ff @(posedge clk) begin
    if (reset || abort) begin
      running <= 1'b0;
      count_reg <= 6'h00;
      profile_ds_reg <= 1'b0;
    end else if (start) begin
      running <= 1'b1;
      count_reg <= 6'h01;
      profile_ds_reg <= from_deep_sleep;
    end else if (running) begin
      count_reg <= count_reg + 6'h01;
      if (count_reg == done_at) begin
        running <= 1'b0;
      end
    end
  end

  // Flags run one cycle ahead of the registered enables they feed, so done
  // lands the mode change on the timeout cycle itself, never before it
  assign fast_osc_stage = running && (count_reg >= osc_at);
  assign proc_clk_stage = running && (count_reg >= clk_at);
  assign done           = running && (count_reg == done_at);
endmodule
`default_nettype wire

/* pms_power_mode_sequencer.sv */
// Purpose: Power mode controller: Processing, Deep Sleep, Self Wake-up
// Assumes: clk is the free-running slow oscillator; commands are one-cycle pulses
// Notes:   Wake line and I2C start arrive asynchronously and are synchronised
`default_nettype none
module pms_power_mode_sequencer
  import pms_pkg::*;
#(
  parameter int CHANNELS = RX_CHANNELS
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Reset sources
  input  wire logic                master_clear_pin,
  input  wire logic                software_reset,
  input  wire logic                watchdog_reset,
  // Host wake sources, asynchronous
  input  wire logic                host_wake_line,
  input  wire logic                i2c_start_seen,
  // Commands from the processor
  input  wire logic                cmd_deep_sleep,
  input  wire logic                cmd_self_wake,
  input  wire logic                inactivity_timeout,
  input  wire logic                approach_detected,
  input  wire logic [15:0]         wake_period,
  input  wire logic                wake_period_load,
  input  wire logic [15:0]         scan_length,
  input  wire logic [CHANNELS-1:0] scan_channel_mask,
  // Power and clock enables
  output logic                     system_reset,
  output logic                     ref_enable,
  output logic                     fast_osc_enable,
  output logic                     processor_clock_gate,
  output logic                     flash_supply_domain,
  output logic                     analog_supply_domain,
  output logic                     core_supply_domain,
  output logic                     watchdog_enable,
  output logic                     peripherals_active,
  output logic                     host_pins_armed,
  output logic [CHANNELS-1:0]      rx_channel_enable,
  output logic [2:0]               mode
);
  // The channel mask is at most one byte wide
  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must be 1 to 8");
  end

  pms_state_t  state_reg;
  pms_state_t  state_next;
  logic [1:0]  wake_sync;
  logic        wake_req;
  logic        any_reset;
  logic        seq_start;
  logic        seq_from_ds;
  logic        seq_running;
  logic        seq_osc;
  logic        seq_clk;
  logic        seq_done;
  logic        start_pending_reg;
  logic        start_ds_reg;
  logic [15:0] period_reg;
  logic [15:0] scan_len_reg;
  logic [15:0] tick_reg;
  logic        timer_overflow;
  logic        scan_over;

  // Sleep states: flash and analog domains off, wake sources watched
  function automatic logic fn_sleeping(input pms_state_t st);
    return st == PMS_DEEP_SLEEP || st == PMS_SW_SLEEP;
  endfunction

  // Self Wake-up phases, both paced by the wake-up timer
  function automatic logic fn_self_wake(input pms_state_t st);
    return st == PMS_SW_SLEEP || st == PMS_SW_SCAN;
  endfunction

  // every register here runs on the slow oscillator clock
  pms_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk     (clk),
    .reset   (reset),
    .async_in({i2c_start_seen, host_wake_line}),
    .sync_out(wake_sync)
  );

  assign any_reset = reset || master_clear_pin || software_reset || watchdog_reset;
  // Simultaneous wake sources merge into one request; resets override below
  assign wake_req  = |wake_sync;

  pms_seq_timer u_seq (
    .clk            (clk),
    .reset          (any_reset),
    .start          (seq_start),
    .from_deep_sleep(seq_from_ds),
    .abort          (state_reg != PMS_POWER_UP),
    .running        (seq_running),
    .fast_osc_stage (seq_osc),
    .proc_clk_stage (seq_clk),
    .done           (seq_done)
  );

  // Sequence starts one cycle after reset release so reset is not sampled asynchronously
  always_ff @(posedge clk) begin
    if (any_reset) begin
      start_pending_reg <= 1'b1;
      start_ds_reg      <= 1'b0;
    end else begin
      start_pending_reg <= 1'b0;
      start_ds_reg      <= 1'b0;
      if (fn_sleeping(state_reg) && wake_req) begin
        start_pending_reg <= 1'b1;
        start_ds_reg      <= 1'b1;
      end else if (state_reg == PMS_SW_SLEEP && timer_overflow) begin
        start_pending_reg <= 1'b0;
      end
    end
  end
  assign seq_start   = start_pending_reg && state_reg == PMS_POWER_UP;
  assign seq_from_ds = start_ds_reg;

  // Wake-up timer: programmable period, adjustable by approach detection
  always_ff @(posedge clk) begin
    if (any_reset) begin
      scan_len_reg <= SCAN_LEN_RST;
    end else if (wake_period_load) begin
      scan_len_reg <= scan_length;
    end
  end

  // A load wins over an approach halving in the same cycle
  always_ff @(posedge clk) begin
    if (any_reset) begin
      period_reg   <= WAKE_PERIOD_RST;
    end else if (wake_period_load) begin
      period_reg   <= wake_period;
    end else if (approach_detected && period_reg > 16'h0001) begin
      period_reg   <= {1'b0, period_reg[15:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (any_reset || state_reg != state_next) begin
      tick_reg <= 16'h0000;
    end else if (fn_self_wake(state_reg)) begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end
  assign timer_overflow = state_reg == PMS_SW_SLEEP && tick_reg >= period_reg - 16'h0001;
  assign scan_over      = state_reg == PMS_SW_SCAN && tick_reg >= scan_len_reg - 16'h0001;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PMS_POWER_UP: begin
        if (seq_done) begin
          state_next = PMS_PROCESSING;
        end
      end
      PMS_PROCESSING: begin
        if (cmd_deep_sleep) begin
          state_next = PMS_POWER_DOWN;
        end else if (cmd_self_wake || inactivity_timeout) begin
          state_next = PMS_SW_SLEEP;
        end
      end
      PMS_POWER_DOWN: begin
        state_next = PMS_DEEP_SLEEP;
      end
      PMS_DEEP_SLEEP: begin
        if (wake_req) begin
          state_next = PMS_POWER_UP;
        end
      end
      PMS_SW_SLEEP: begin
        if (wake_req) begin
          state_next = PMS_POWER_UP;
        end else if (timer_overflow) begin
          state_next = PMS_SW_SCAN;
        end
      end
      PMS_SW_SCAN: begin
        if (wake_req) begin
          state_next = PMS_PROCESSING;
        end else if (scan_over) begin
          state_next = PMS_SW_SLEEP;
        end
      end
      default: begin
        state_next = PMS_POWER_UP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (any_reset) begin
      state_reg <= PMS_POWER_UP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset flag and reported mode; mode follows the next state so it lines up with state_reg
  always_ff @(posedge clk) begin
    if (any_reset) begin
      system_reset <= 1'b1;
      mode         <= PMS_POWER_UP;
    end else begin
      system_reset <= 1'b0;
      mode         <= state_next;
    end
  end

  // Staged clock enables; the sequence counter paces them during power-up
  always_ff @(posedge clk) begin
    if (any_reset) begin
      ref_enable           <= 1'b0;
      fast_osc_enable      <= 1'b0;
      processor_clock_gate <= 1'b0;
    end else begin
      unique case (state_next)
        PMS_POWER_UP: begin
          ref_enable           <= seq_start || seq_running;
          fast_osc_enable      <= seq_osc;
          processor_clock_gate <= seq_clk;
        end
        PMS_PROCESSING: begin
          ref_enable           <= 1'b1;
          fast_osc_enable      <= 1'b1;
          processor_clock_gate <= 1'b1;
        end
        PMS_POWER_DOWN: begin
          ref_enable           <= 1'b0;
          fast_osc_enable      <= 1'b0;
          processor_clock_gate <= 1'b0;
        end
        PMS_DEEP_SLEEP: begin
          ref_enable           <= 1'b0;
          fast_osc_enable      <= 1'b0;
          processor_clock_gate <= 1'b0;
        end
        PMS_SW_SLEEP: begin
          ref_enable           <= 1'b0;
          fast_osc_enable      <= 1'b0;
          processor_clock_gate <= 1'b0;
        end
        PMS_SW_SCAN: begin
          ref_enable           <= 1'b1;
          fast_osc_enable      <= 1'b1;
          processor_clock_gate <= 1'b1;
        end
        default: begin
          ref_enable           <= 1'b0;
          fast_osc_enable      <= 1'b0;
          processor_clock_gate <= 1'b0;
        end
      endcase
    end
  end

  // Supplies: only the core domain survives the sleep states
  always_ff @(posedge clk) begin
    if (any_reset) begin
      flash_supply_domain  <= 1'b1;
      analog_supply_domain <= 1'b1;
      core_supply_domain   <= 1'b1;
    end else begin
      flash_supply_domain  <= !fn_sleeping(state_next);
      analog_supply_domain <= !fn_sleeping(state_next);
      core_supply_domain   <= 1'b1;
    end
  end

  // Watchdog stays on in the Self Wake-up sleep phase, since a watchdog
  // reset is one of the ways that phase may end
  always_ff @(posedge clk) begin
    if (any_reset) begin
      watchdog_enable    <= 1'b0;
      peripherals_active <= 1'b0;
      host_pins_armed    <= 1'b0;
    end else begin
      unique case (state_next)
        PMS_POWER_UP: begin
          watchdog_enable    <= 1'b0;
          peripherals_active <= 1'b0;
          host_pins_armed    <= 1'b0;
        end
        PMS_PROCESSING: begin
          watchdog_enable    <= 1'b1;
          peripherals_active <= 1'b1;
          host_pins_armed    <= 1'b0;
        end
        PMS_POWER_DOWN: begin
          watchdog_enable    <= 1'b0;
          peripherals_active <= 1'b0;
          host_pins_armed    <= 1'b1;
        end
        PMS_DEEP_SLEEP: begin
          watchdog_enable    <= 1'b0;
          peripherals_active <= 1'b0;
          host_pins_armed    <= 1'b1;
        end
        PMS_SW_SLEEP: begin
          watchdog_enable    <= 1'b1;
          peripherals_active <= 1'b0;
          host_pins_armed    <= 1'b1;
        end
        PMS_SW_SCAN: begin
          watchdog_enable    <= 1'b1;
          peripherals_active <= 1'b1;
          host_pins_armed    <= 1'b1;
        end
        default: begin
          watchdog_enable    <= 1'b0;
          peripherals_active <= 1'b0;
          host_pins_armed    <= 1'b0;
        end
      endcase
    end
  end

  // Receive channel enables, one flip-flop per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_rx
    always_ff @(posedge clk) begin
      if (any_reset) begin
        rx_channel_enable[ch] <= 1'b0;
      end else if (state_next == PMS_SW_SCAN) begin
        rx_channel_enable[ch] <= scan_channel_mask[ch];
      end else begin
        rx_channel_enable[ch] <= state_next == PMS_PROCESSING;
      end
    end
  end
endmodule
`default_nettype wire

/* pms_power_mode_sequencer_asserts.sv */
// Purpose: Port-level assertions for the power mode sequencer
// Assumes: One slow clock domain, synchronous active-high reset
// Notes:   Mode codes follow the package state encoding
`default_nettype none
module pms_power_mode_sequencer_asserts
  import pms_pkg::*;
#(
  parameter int CHANNELS = RX_CHANNELS
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // Causes
  input wire logic                master_clear_pin,
  input wire logic                software_reset,
  input wire logic                watchdog_reset,
  input wire logic                host_wake_line,
  input wire logic                i2c_start_seen,
  input wire logic                cmd_deep_sleep,
  input wire logic                cmd_self_wake,
  input wire logic                inactivity_timeout,
  input wire logic [CHANNELS-1:0] scan_channel_mask,
  // Effects
  input wire logic                system_reset,
  input wire logic                ref_enable,
  input wire logic                fast_osc_enable,
  input wire logic                processor_clock_gate,
  input wire logic                flash_supply_domain,
  input wire logic                analog_supply_domain,
  input wire logic                core_supply_domain,
  input wire logic                watchdog_enable,
  input wire logic                host_pins_armed,
  input wire logic [CHANNELS-1:0] rx_channel_enable,
  input wire logic [2:0]          mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_fast_stage;
    !fast_osc_enable ##1 $rose(fast_osc_enable);
  endsequence

  chk_ds_supply: assert property (mode == 3'h3 |->
    !flash_supply_domain && !analog_supply_domain && core_supply_domain)
    else $error("deep sleep supplies wrong");
  chk_ds_clocks: assert property (mode == 3'h3 |-> !fast_osc_enable &&
    !processor_clock_gate && !watchdog_enable && host_pins_armed)
    else $error("deep sleep clocks wrong");
  chk_ds_entry: assert property ((mode == 3'h3 && $past(mode) != 3'h3) |->
    $past(mode) == 3'h2) else $error("deep sleep entered without power-down");
  chk_pd_analog: assert property (mode == 3'h2 |->
    !ref_enable && !fast_osc_enable && !processor_clock_gate)
    else $error("analog enable up in power-down");
  chk_pd_cause: assert property ((mode == 3'h2 && $past(mode) == 3'h1) |->
    $past(cmd_deep_sleep)) else $error("power-down without command");
  chk_sw_entry: assert property ((mode == 3'h4 && $past(mode) == 3'h1) |->
    $past(cmd_self_wake) || $past(inactivity_timeout))
    else $error("self wake entered without cause");
  chk_ds_wake: assert property (($past(mode) == 3'h3 && mode != 3'h3) |->
    system_reset || $past(host_wake_line, 2) || $past(host_wake_line, 3) ||
    $past(i2c_start_seen, 2) || $past(i2c_start_seen, 3))
    else $error("deep sleep left without wake");
  chk_reset_merge: assert property ((master_clear_pin || software_reset ||
    watchdog_reset) |=> system_reset) else $error("system reset missing");
  chk_fast_stage: assert property (($rose(ref_enable) && mode == 3'h0) |=> s_fast_stage)
    else $error("fast oscillator stage mistimed");
  chk_start_after: assert property ((mode == 3'h1 && $past(mode) == 3'h0) |->
    $past(processor_clock_gate, 2)) else $error("processing before timeout");
  chk_scan_mask: assert property (mode == 3'h5 |->
    rx_channel_enable == scan_channel_mask) else $error("scan channels wrong");
endmodule

bind pms_power_mode_sequencer pms_power_mode_sequencer_asserts #(
  .CHANNELS(CHANNELS)
) i_asserts (.*);
`default_nettype wire

/* pms_host_model.sv */
// Purpose: Host processor model driving wake sources and commands
// Assumes: Commands are one-cycle pulses after a clock edge
// Notes:   Wake sources are released low after the hold time
`default_nettype none
module pms_host_model (
  // Clock
  input  wire logic clk,
  // Toward the device
  output var logic  host_wake_line,
  output var logic  i2c_start_seen,
  output var logic  cmd_deep_sleep,
  output var logic  cmd_self_wake,
  output var logic  inactivity_timeout
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {host_wake_line, i2c_start_seen} = 2'b00;
    {cmd_deep_sleep, cmd_self_wake, inactivity_timeout} = 3'b000;
  end
  // Kind 0 deep sleep, 1 self wake, 2 inactivity
  task automatic command(input int kind);
    @(posedge clk);
    #1;
    {cmd_deep_sleep, cmd_self_wake, inactivity_timeout} = {kind == 0, kind == 1, kind == 2};
    @(posedge clk);
    #1;
    {cmd_deep_sleep, cmd_self_wake, inactivity_timeout} = 3'b000;
  endtask
  // Long hold models a slow host; the line drops back to idle after
  task automatic wake(input bit use_i2c, input int hold);
    @(posedge clk);
    #1;
    if (use_i2c) begin
      i2c_start_seen = 1'b1;
    end else begin
      host_wake_line = 1'b1;
    end
    repeat (hold) @(posedge clk);
    #1;
    {host_wake_line, i2c_start_seen} = 2'b00;
  endtask
endmodule
`default_nettype wire

/* pms_power_mode_sequencer_tb.sv */
// Purpose: Self-checking bench for the power mode sequencer
// Assumes: Host model drives wake sources and commands
// Notes:   Sleep timer loaded short so Self Wake-up cycles quickly
`default_nettype none
module pms_power_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pms_pkg::*;
  logic clk = 1'b0, reset = 1'b1;
  logic master_clear_pin = 1'b0, software_reset = 1'b0, watchdog_reset = 1'b0;
  logic approach_detected = 1'b0, wake_period_load = 1'b0;
  logic [15:0] wake_period = 16'h0020, scan_length = 16'h0004;
  logic [RX_CHANNELS-1:0] scan_channel_mask = 5'h05;
  wire logic host_wake_line, i2c_start_seen, cmd_deep_sleep, cmd_self_wake;
  wire logic inactivity_timeout, system_reset, ref_enable, fast_osc_enable;
  wire logic processor_clock_gate, flash_supply_domain, analog_supply_domain;
  wire logic core_supply_domain, watchdog_enable, peripherals_active, host_pins_armed;
  wire logic [RX_CHANNELS-1:0] rx_channel_enable;
  wire logic [2:0] mode;
  int bad_count = 0, tests_run = 0, cycles = 0;

  pms_power_mode_sequencer i_dut (.*);
  pms_host_model i_host (.*);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim) begin
      tick();
      n++;
    end
  endtask
  // Counts stages from the cycle the reference enable is seen high
  task automatic measure(input int ef, input int ep, input int ed);
    int n, tf, tp;
    {n, tf, tp} = '0;
    while (ref_enable === 1'b1 && n < 9) begin
      tick();
      n++;
    end
    n = 0;
    while (ref_enable !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    n = 0;
    while (mode !== 3'h1 && n < 60) begin
      tick();
      n++;
      if (fast_osc_enable === 1'b1 && tf == 0) tf = n;
      if (processor_clock_gate === 1'b1 && tp == 0) tp = n;
    end
    check(16'(tf), 16'(ef));
    check(16'(tp), 16'(ep));
    check(16'(n >= ed && n <= ed + 1), 16'h0001);
    check({flash_supply_domain, analog_supply_domain, core_supply_domain, peripherals_active,
           watchdog_enable, rx_channel_enable}, 16'h03FF);
  endtask
  task automatic ds_enter();
    i_host.command(0);
    check({mode, ref_enable, fast_osc_enable, processor_clock_gate}, 16'h0010);
    tick();
    check({mode, flash_supply_domain, analog_supply_domain, core_supply_domain, fast_osc_enable,
           processor_clock_gate, watchdog_enable, host_pins_armed}, 16'h0191);
  endtask
  task automatic t_deep_sleep();
    ds_enter();
    i_host.command(1);
    tick(2);
    check(16'(mode), 16'h0003);
    // Measure runs beside the wake so it sees the reference enable rise
    fork
      i_host.wake(0, 4);
      measure(2, 8, 10);
    join
    ds_enter();
    fork
      i_host.wake(1, 4);
      measure(2, 8, 10);
    join
  endtask
  task automatic t_self_wake();
    int n, l1, l3;
    wake_period_load = 1'b1;
    tick();
    wake_period_load = 1'b0;
    i_host.command(1);
    wait_mode(3'h4, 3, n);
    check(16'(mode), 16'h0004);
    wait_mode(3'h5, 100, l1);
    check(16'(rx_channel_enable), 16'(scan_channel_mask));
    wait_mode(3'h4, 40, n);
    check(16'(mode), 16'h0004);
    approach_detected = 1'b1;
    tick();
    approach_detected = 1'b0;
    wait_mode(3'h5, 100, n);
    wait_mode(3'h4, 40, n);
    wait_mode(3'h5, 100, l3);
    check(16'(l3 < l1), 16'h0001);
    i_host.wake(0, 4);
    wait_mode(3'h1, WAKE_MAX_CYCLES, n);
    check(16'(mode), 16'h0001);
    i_host.command(2);
    wait_mode(3'h4, 3, n);
    check(16'(mode), 16'h0004);
    // Wake in the sleep phase reruns the short power-up profile
    fork
      i_host.wake(1, 4);
      measure(2, 8, 10);
    join
    i_host.command(2);
    wait_mode(3'h4, 3, n);
    check(16'(mode), 16'h0004);
    watchdog_reset = 1'b1;
    tick();
    watchdog_reset = 1'b0;
    check(16'(system_reset), 16'h0001);
    measure(2, 30, 36);
  endtask
  task automatic t_resets();
    ds_enter();
    // Master clear lands on the edge where the synchronised wake is first seen
    fork
      i_host.wake(0, 4);
      begin
        tick(3);
        master_clear_pin = 1'b1;
        tick();
        master_clear_pin = 1'b0;
      end
      measure(2, 30, 36);
    join
    software_reset = 1'b1;
    tick();
    software_reset = 1'b0;
    check(16'(system_reset), 16'h0001);
    measure(2, 30, 36);
  endtask

  initial begin
    tick(5);
    reset = 1'b0;
    measure(2, 30, 36);
    t_deep_sleep();
    t_self_wake();
    t_resets();
    finish_test();
  end
endmodule
`default_nettype wire
